// ---- sim/shm_homing_monitor.sv ----
// Port-level checker for the homing block
`default_nettype none
module shm_homing_monitor
    import shm_pkg::*;
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [15:0] controlword,
    input wire logic        homing_control_mode,
    input wire logic        method_supported,
    input wire logic        absolute_mode,
    input wire logic        overshoot_done,
    input wire logic [15:0] actual_speed,
    input wire logic [15:0] max_speed,
    input wire logic [15:0] overspeed_level,
    input wire logic [15:0] statusword_bits,
    input wire logic [31:0] position_demand_internal,
    input wire logic [31:0] position_actual_internal,
    input wire logic        probe_stale,
    input wire logic        origin_store,
    input wire logic        returning,
    input wire logic [15:0] speed_cmd,
    input wire logic        position_init_error,
    input wire logic        overspeed_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Return completion, speed and error checks
    // ----------------------------------------
    // Completion counts only when the run is not cancelled in the same cycle
    sequence ret_end_s;
        returning && overshoot_done && controlword[4] && homing_control_mode;
    endsequence
    sequence preset_s;
        position_demand_internal == SHM_POS_ZERO && position_actual_internal == SHM_POS_ZERO
            && probe_stale;
    endsequence
    preset_zero_a: assert property (ret_end_s |=> preset_s)
        else $error("internal positions not cleared at preset");
    attain_seq_a: assert property (ret_end_s ##1 preset_s |=> statusword_bits[12])
        else $error("attained not set after return move");
    origin_save_a: assert property (ret_end_s ##0 absolute_mode |=> origin_store)
        else $error("origin store missing in absolute mode");
    speed_idle_a: assert property (!returning ##1 !returning |-> speed_cmd == 16'h0000)
        else $error("speed command outside return move");
    speed_cap_a: assert property (returning ##1 returning |-> speed_cmd <= max_speed)
        else $error("speed command above motor maximum");
    overspeed_a: assert property (returning && actual_speed > overspeed_level
        |-> ##[1:2] overspeed_error)
        else $error("over-speed not flagged");
    cancel_err_a: assert property (returning && !controlword[4] |-> ##[1:2] position_init_error)
        else $error("cancel in return not flagged");
    bad_method_a: assert property ($rose(controlword[4]) && homing_control_mode && !method_supported
        |=> statusword_bits[13])
        else $error("unsupported method not flagged");
endmodule : shm_homing_monitor

bind shm_homing shm_homing_monitor u_mon (.clock(clock), .rstn(rstn), .controlword(controlword),
    .homing_control_mode(homing_control_mode), .method_supported(method_supported),
    .absolute_mode(absolute_mode), .overshoot_done(overshoot_done), .actual_speed(actual_speed),
    .max_speed(max_speed), .overspeed_level(overspeed_level), .statusword_bits(statusword_bits),
    .position_demand_internal(position_demand_internal),
    .position_actual_internal(position_actual_internal), .probe_stale(probe_stale),
    .origin_store(origin_store), .returning(returning), .speed_cmd(speed_cmd),
    .position_init_error(position_init_error), .overspeed_error(overspeed_error));
`default_nettype wire

// ---- sim/shm_host_model.sv ----
// Fieldbus host model that sequences the homing start bit
`default_nettype none
module shm_host_model
    import shm_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8 // Shortened settle wait after enable
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        start_req,
    output logic      [15:0] controlword,
    output logic             ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int settle_q;
    // Hold commands back until the drive has settled after enable
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            settle_q <= 0;
        end else if (settle_q < SETTLE_CYCLES) begin
            settle_q <= settle_q + 1;
        end
    end
    assign ready = (settle_q >= SETTLE_CYCLES);
    // Start bit only moves once settled, so each start is a fresh 0-to-1 edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            controlword <= 16'h0000;
        end else begin
            controlword[SHM_BIT_START] <= start_req && ready;
        end
    end
endmodule : shm_host_model
`default_nettype wire

// ---- sim/test_servo_homing_sequence.sv ----
// Self-checking bench for the servo homing block
`default_nettype none
module test_servo_homing_sequence import shm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rstn = 1'b0, start_req = 1'b0, ready, mode = 1'b1, msup = 1'b1;
    logic        edge_m = 1'b1, idx_m = 1'b0, abs_m = 1'b0, fclosed = 1'b0, enc_z = 1'b0;
    logic        scl_z = 1'b0, pos_ot = 1'b0, neg_ot = 1'b0, done_in = 1'b0;
    shm_obj_s    obj = '0;
    shm_sw_s     sw = '{1'b0, 1'b0, 1'b0, 1'b0, SHM_LATCH_HOME, SHM_LATCH_POS, SHM_LATCH_NEG};
    logic [15:0] req_spd = 16'h1388, min_spd = 16'h0064, max_spd = 16'h0bb8, act_spd = 16'h0000;
    logic [15:0] ovs_lvl = 16'hffff, ovs2_lvl = 16'hffff, cw, stat, spd, ext_rd, lim_rd;
    logic [31:0] pd, pa, pdi, pai;
    logic        stale, ostore, ret, e_init, e_two, e_ovs, e_ovs2;
    int          bad_count = 0, total_checks = 0, i;

    shm_host_model #(.SETTLE_CYCLES(8)) host (.clock(clock), .rstn(rstn),
        .start_req(start_req), .controlword(cw), .ready(ready));
    shm_homing dut (.clock(clock), .rstn(rstn), .obj(obj), .controlword(cw),
        .homing_control_mode(mode), .method_supported(msup), .edge_method(edge_m),
        .index_method(idx_m), .absolute_mode(abs_m), .full_closed(fclosed), .encoder_z(enc_z),
        .scale_z(scl_z), .sw(sw), .positive_overtravel_input(pos_ot),
        .negative_overtravel_input(neg_ot), .overshoot_done(done_in), .request_speed(req_spd),
        .actual_speed(act_spd), .min_speed(min_spd), .max_speed(max_spd),
        .overspeed_level(ovs_lvl), .second_overspeed_level(ovs2_lvl), .statusword_bits(stat),
        .position_demand(pd), .position_actual(pa), .position_demand_internal(pdi),
        .position_actual_internal(pai), .probe_stale(stale), .origin_store(ostore),
        .returning(ret), .speed_cmd(spd), .position_init_error(e_init),
        .home_return_error_two(e_two), .overspeed_error(e_ovs), .second_overspeed_error(e_ovs2),
        .ext_setup_rd(ext_rd), .ret_limit_rd(lim_rd));

    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : chk
    task automatic wr(input logic [15:0] idx, input logic [31:0] data);
        obj = '{wr: 1'b1, index: idx, data: data};
        @(negedge clock);
        obj.wr = 1'b0;
        @(negedge clock); // Idle cycle so back-to-back writes never glitch the strobe
    endtask : wr
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic start(input int n);
        start_req = 1'b1;
        repeat (n) @(negedge clock);
    endtask : start
    task automatic stop;
        start_req = 1'b0;
        repeat (3) @(negedge clock);
    endtask : stop
    // Start refused: flag raised, no motion
    task automatic bad_start;
        start(3);
        chk("homing_error", 1, stat[SHM_BIT_HOMING_ERR]);
        chk("returning", 0, ret);
        stop();
    endtask : bad_start
    // Start, find home, check clamped return speed
    task automatic home_run(input logic idx, input logic [15:0] exp_spd);
        start(3);
        chk("homing_error", 0, stat[SHM_BIT_HOMING_ERR]);
        if (idx) begin
            enc_z = 1'b1; // Encoder index must be ignored under full-closed control
            @(negedge clock);
            enc_z = 1'b0;
            chk("returning", 0, ret);
            scl_z = 1'b1;
        end else begin
            sw.home_edge = 1'b1;
        end
        @(negedge clock);
        scl_z = 1'b0;
        sw.home_edge = 1'b0;
        for (i = 0; i < 20 && ret !== 1'b1; i++) @(negedge clock);
        chk("returning", 1, ret);
        if (ret !== 1'b1) finish_test();
        repeat (2) @(negedge clock);
        chk("speed_cmd", exp_spd, spd);
    endtask : home_run
    // Finish the return move and check the preset
    task automatic home_end(input logic [31:0] off);
        done_in = 1'b1;
        @(negedge clock);
        done_in = 1'b0;
        // Presets are up one edge after completion; the origin store pulse stands only now
        chk("pos_demand", off, pd);
        chk("pos_actual", off, pa);
        chk("pos_internal", 0, pdi | pai);
        chk("probe_stale", 1, stale);
        chk("origin_store", abs_m, ostore);
        @(negedge clock);
        chk("attained", 1, stat[SHM_BIT_ATTAINED]);
        stop();
    endtask : home_end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        for (i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clock);
        chk("host_ready", 1, ready);
        if (ready !== 1'b1) finish_test();
        chk("ext_setup", SHM_RST_EXT_SETUP, ext_rd);
        chk("ret_limit", SHM_RST_RET_LIMIT, lim_rd);
        wr(SHM_IDX_RET_SPD_LIMIT, 32'h0000_4e21);
        chk("ret_limit", SHM_RST_RET_LIMIT, lim_rd);
        wr(SHM_IDX_RET_SPD_LIMIT, {16'h0000, SHM_SPD_RANGE_MAX});
        chk("ret_limit", SHM_SPD_RANGE_MAX, lim_rd);
        wr(SHM_IDX_EXT_SETUP, 32'h0000_0040);
        wr(16'h3700, 32'h0000_ffff);
        chk("ext_setup", 16'h0040, ext_rd);
        wr(SHM_IDX_RET_SPD_LIMIT, 32'h0000_03e8);
        $display("test registers done");
        msup = 1'b0;
        bad_start();
        msup = 1'b1;
        sw.home_pin = 3'h4;
        bad_start();
        sw.home_pin = SHM_LATCH_HOME;
        $display("test refused starts done");
        wr(SHM_IDX_HOME_OFFSET, 32'h0000_1234);
        home_run(1'b0, 16'h03e8);
        wr(SHM_IDX_HOME_OFFSET, 32'h0000_5678);
        home_end(32'h0000_1234);
        chk("overspeed", 0, e_ovs);
        $display("test edge homing done");
        {edge_m, idx_m, fclosed, abs_m} = 4'h7;
        wr(SHM_IDX_EXT_SETUP, 32'h0000_0080);
        act_spd = 16'h0c00;
        ovs_lvl = 16'h0bb8;
        ovs2_lvl = 16'h0bb8;
        home_run(1'b1, 16'h0bb8);
        chk("overspeed", 1, e_ovs);
        chk("second_overspeed", 1, e_ovs2);
        act_spd = 16'h0000;
        home_end(32'h0000_5678);
        chk("error_two", 0, e_two);
        $display("test index homing done");
        {edge_m, idx_m, fclosed, abs_m} = 4'h8;
        wr(SHM_IDX_EXT_SETUP, 32'h0000_0040);
        wr(SHM_IDX_RET_SPD_LIMIT, 32'h0000_0032);
        home_run(1'b0, 16'h0064);
        stop();
        chk("init_error", 1, e_init);
        chk("attained", 1, stat[SHM_BIT_ATTAINED]);
        $display("test cancel done");
        {edge_m, idx_m} = 2'b01;
        wr(SHM_IDX_EXT_SETUP, 32'h0000_0080);
        start(3);
        pos_ot = 1'b1;
        @(negedge clock);
        pos_ot = 1'b0;
        repeat (2) @(negedge clock);
        chk("error_two", 1, e_two);
        stop();
        $display("test index overtravel done");
        finish_test();
    end
endmodule : test_servo_homing_sequence
`default_nettype wire

// ---- src/shm_homing.sv ----
// Homing-mode control for a servo drive
//
// Summary of operation
// - On homing completion, positions preset to offset/zero.
// - Offset written mid-run applies at the next run's completion.
// - Edge-based home needs latch inputs five-seven.
// - Cancel after origin before return raises error.
// - Earlier success keeps homing treated as complete.
// - Inhibit during index search raises error two.
// - Return overshoot distance completes homing.
// - Limit enable bit caps return speed.
// - Disabled limit uses only motor maximum.
// - Return speed above level raises overspeed.
// - Above second level raises second overspeed.
// - Limit clamped between internal minimum and maximum.
// - Absolute homing stores origin to nonvolatile.
// - Index from encoder or scale per control.
// - Only rising start bit starts homing.
// - Homing error flag, including unsupported method.
`default_nettype none
module shm_homing
    import shm_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire shm_pkg::shm_obj_s    obj,
    input  wire logic [15:0]          controlword,
    input  wire logic                 homing_control_mode,
    input  wire logic                 method_supported,
    input  wire logic                 edge_method,
    input  wire logic                 index_method,
    input  wire logic                 absolute_mode,
    input  wire logic                 full_closed,
    input  wire logic                 encoder_z,
    input  wire logic                 scale_z,
    input  wire shm_pkg::shm_sw_s     sw,
    input  wire logic                 positive_overtravel_input,
    input  wire logic                 negative_overtravel_input,
    input  wire logic                 overshoot_done,
    input  wire logic [15:0]          request_speed,
    input  wire logic [15:0]          actual_speed,
    input  wire logic [15:0]          min_speed,
    input  wire logic [15:0]          max_speed,
    input  wire logic [15:0]          overspeed_level,
    input  wire logic [15:0]          second_overspeed_level,
    output logic [15:0]               statusword_bits,
    output logic [31:0]               position_demand,
    output logic [31:0]               position_actual,
    output logic [31:0]               position_demand_internal,
    output logic [31:0]               position_actual_internal,
    output logic                      probe_stale,
    output logic                      origin_store,
    output logic                      returning,
    output logic [15:0]               speed_cmd,
    output logic                      position_init_error,
    output logic                      home_return_error_two,
    output logic                      overspeed_error,
    output logic                      second_overspeed_error,
    output logic [15:0]               ext_setup_rd,
    output logic [15:0]               ret_limit_rd
);
    import shm_pkg::*;

    // ------------------------------------------------------------------
    // Object registers
    // ------------------------------------------------------------------
    shm_state_e  state_q;
    logic [15:0] ext_setup_q;
    logic [15:0] ret_limit_q;
    logic [31:0] home_offset_q;
    logic [31:0] run_offset_q;
    logic        start_q;
    logic        attained_q;
    logic        ever_done_q;
    logic        herr_q;
    logic        os_flag;
    logic        os2_flag;

    logic start_rise;
    logic index_seen;
    logic cancel;
    logic assign_ok;
    logic inhibit;

    // Host writes to the objects
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_setup_q   <= SHM_RST_EXT_SETUP;
            ret_limit_q   <= SHM_RST_RET_LIMIT;
            home_offset_q <= SHM_POS_ZERO;
        end else if (obj.wr) begin
            if (obj.index == SHM_IDX_EXT_SETUP) begin
                ext_setup_q <= obj.data[15:0];
            end
            if (obj.index == SHM_IDX_RET_SPD_LIMIT && obj.data[15:0] <= SHM_SPD_RANGE_MAX) begin
                ret_limit_q <= obj.data[15:0];
            end
            if (obj.index == SHM_IDX_HOME_OFFSET) begin
                home_offset_q <= obj.data;
            end
        end
    end

    assign ext_setup_rd = ext_setup_q;
    assign ret_limit_rd = ret_limit_q;

    // ------------------------------------------------------------------
    // Sequence decode
    // ------------------------------------------------------------------
    assign start_rise = controlword[SHM_BIT_START] && !start_q;
    assign index_seen = full_closed ? scale_z : encoder_z;
    assign assign_ok  = !edge_method || ((sw.home_pin == SHM_LATCH_HOME)
                        && (sw.pos_pin == SHM_LATCH_POS)
                        && (sw.neg_pin == SHM_LATCH_NEG));
    assign inhibit    = positive_overtravel_input || negative_overtravel_input;
    assign cancel     = !controlword[SHM_BIT_START] || !homing_control_mode;

    // Start bit history
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= controlword[SHM_BIT_START];
        end
    end

    // Homing state machine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= SHM_IDLE;
        end else begin
            case (state_q)
                SHM_IDLE: begin
                    if (homing_control_mode && start_rise && method_supported && assign_ok) begin
                        state_q <= index_method ? SHM_INDEX : SHM_SEARCH;
                    end
                end
                SHM_SEARCH: begin
                    if (cancel) begin
                        state_q <= SHM_IDLE;
                    end else if (sw.home_edge || sw.pos_edge || sw.neg_edge) begin
                        state_q <= SHM_RETURN;
                    end
                end
                SHM_INDEX: begin
                    if (cancel || (ext_setup_q[SHM_BIT_Z_OT_EN] && inhibit)) begin
                        state_q <= SHM_IDLE;
                    end else if (index_seen) begin
                        state_q <= SHM_RETURN;
                    end
                end
                SHM_RETURN: begin
                    if (cancel) begin
                        state_q <= SHM_IDLE;
                    end else if (overshoot_done) begin
                        state_q <= SHM_DONE;
                    end
                end
                SHM_DONE: begin
                    state_q <= SHM_IDLE;
                end
                default: begin
                    state_q <= SHM_IDLE;
                end
            endcase
        end
    end

    // Offset snapshot taken at start; later writes wait for next run
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_offset_q <= SHM_POS_ZERO;
        end else if (state_q == SHM_IDLE) begin
            run_offset_q <= home_offset_q;
        end
    end

    // ------------------------------------------------------------------
    // Position preset at homing completion
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            position_demand          <= SHM_POS_ZERO;
            position_actual          <= SHM_POS_ZERO;
            position_demand_internal <= SHM_POS_ZERO;
            position_actual_internal <= SHM_POS_ZERO;
            probe_stale              <= 1'b0;
            origin_store             <= 1'b0;
        end else begin
            origin_store <= 1'b0;
            if (state_q == SHM_RETURN && !cancel && overshoot_done) begin
                position_demand          <= run_offset_q;
                position_actual          <= run_offset_q;
                position_demand_internal <= SHM_POS_ZERO;
                position_actual_internal <= SHM_POS_ZERO;
                probe_stale              <= 1'b1;
                origin_store             <= absolute_mode;
            end else if (start_rise) begin
                probe_stale <= 1'b0;
            end
        end
    end

    // Completion memory and attained status
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ever_done_q <= 1'b0;
            attained_q  <= 1'b0;
        end else begin
            if (state_q == SHM_DONE) begin
                ever_done_q <= 1'b1;
                attained_q  <= 1'b1;
            end else if (state_q == SHM_IDLE) begin
                attained_q  <= ever_done_q;
            end else begin
                attained_q  <= 1'b0;
            end
        end
    end

    // Homing error updated at each start; protection errors sticky until reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            herr_q                <= 1'b0;
            position_init_error   <= 1'b0;
            home_return_error_two <= 1'b0;
            overspeed_error       <= 1'b0;
            second_overspeed_error <= 1'b0;
        end else begin
            if (homing_control_mode && start_rise) begin
                herr_q <= !method_supported || !assign_ok;
            end
            if (state_q == SHM_RETURN && cancel) begin
                position_init_error <= 1'b1;
            end
            if (state_q == SHM_INDEX && ext_setup_q[SHM_BIT_Z_OT_EN] && inhibit) begin
                home_return_error_two <= 1'b1;
            end
            if (os_flag) begin
                overspeed_error <= 1'b1;
            end
            if (os2_flag) begin
                second_overspeed_error <= 1'b1;
            end
        end
    end

    assign returning = (state_q == SHM_RETURN);

    // Status bits: attained and error
    always_comb begin
        statusword_bits = 16'h0000;
        statusword_bits[SHM_BIT_ATTAINED]   = attained_q;
        statusword_bits[SHM_BIT_HOMING_ERR] = herr_q;
    end

    // ------------------------------------------------------------------
    // Return speed limiting
    // ------------------------------------------------------------------
    shm_speed_clamp u_clamp (
        .clock                  (clock),
        .rstn                   (rstn),
        .limit_en               (ext_setup_q[SHM_BIT_RET_LIMIT_EN]),
        .limit_value            (ret_limit_q),
        .min_speed              (min_speed),
        .max_speed              (max_speed),
        .request_speed          (request_speed),
        .actual_speed           (actual_speed),
        .overspeed_level        (overspeed_level),
        .second_overspeed_level (second_overspeed_level),
        .active                 (returning),
        .speed_cmd              (speed_cmd),
        .overspeed              (os_flag),
        .second_overspeed       (os2_flag)
    );
endmodule : shm_homing
`default_nettype wire

// ---- src/shm_pkg.sv ----
// Package for the servo homing sequence block: object indexes, fields, states
`default_nettype none
package shm_pkg;
    // Object indexes reached over the documented object port
    localparam logic [15:0] SHM_IDX_EXT_SETUP     = 16'h3722;
    localparam logic [15:0] SHM_IDX_RET_SPD_LIMIT = 16'h3793;
    localparam logic [15:0] SHM_IDX_HOME_OFFSET   = 16'h607c;
    // Field positions
    localparam int SHM_BIT_RET_LIMIT_EN = 6;  // Homing return speed limit enable
    localparam int SHM_BIT_Z_OT_EN      = 7;  // Over-travel inhibit in index search
    localparam int SHM_BIT_START        = 4;  // Controlword start homing
    localparam int SHM_BIT_HOMING_ERR   = 13; // Statusword homing error
    localparam int SHM_BIT_ATTAINED     = 12; // Statusword homing attained
    // Reset values and speed bounds in r/min
    localparam logic [15:0] SHM_RST_EXT_SETUP  = 16'h0000;
    localparam logic [15:0] SHM_RST_RET_LIMIT  = 16'h0000;
    localparam logic [15:0] SHM_SPD_RANGE_MAX  = 16'h4e20; // 20000 r/min
    localparam logic [31:0] SHM_POS_ZERO       = 32'h0000_0000;
    // Latch-compensated input numbers for home, positive and negative limits
    localparam logic [2:0]  SHM_LATCH_HOME = 3'h5;
    localparam logic [2:0]  SHM_LATCH_POS  = 3'h6;
    localparam logic [2:0]  SHM_LATCH_NEG  = 3'h7;

    typedef enum logic [2:0] {
        SHM_IDLE   = 3'b000,
        SHM_SEARCH = 3'b001,
        SHM_INDEX  = 3'b010,
        SHM_RETURN = 3'b011,
        SHM_DONE   = 3'b100
    } shm_state_e;

    // Object write from the fieldbus host
    typedef struct packed {
        logic        wr;
        logic [15:0] index;
        logic [31:0] data;
    } shm_obj_s;

    // Switch and index inputs with their latch assignments
    typedef struct packed {
        logic       index_pulse;
        logic       home_edge;
        logic       pos_edge;
        logic       neg_edge;
        logic [2:0] home_pin;
        logic [2:0] pos_pin;
        logic [2:0] neg_pin;
    } shm_sw_s;
endpackage : shm_pkg
`default_nettype wire

// ---- src/shm_speed_clamp.sv ----
// Homing return speed clamp and over-speed detection
`default_nettype none
module shm_speed_clamp (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        limit_en,
    input  wire logic [15:0] limit_value,
    input  wire logic [15:0] min_speed,
    input  wire logic [15:0] max_speed,
    input  wire logic [15:0] request_speed,
    input  wire logic [15:0] actual_speed,
    input  wire logic [15:0] overspeed_level,
    input  wire logic [15:0] second_overspeed_level,
    input  wire logic        active,
    output logic      [15:0] speed_cmd,
    output logic             overspeed,
    output logic             second_overspeed
);
    logic [15:0] lim_eff;
    logic [15:0] cap;
    logic [15:0] cmd_d;

    // Bound the set limit into the internal minimum and motor maximum
    always_comb begin
        lim_eff = limit_value;
        if (lim_eff < min_speed) begin
            lim_eff = min_speed;
        end else if (lim_eff > max_speed) begin
            lim_eff = max_speed;
        end
        cap   = limit_en ? lim_eff : max_speed;
        cmd_d = (request_speed > cap) ? cap : request_speed;
    end

    // Registered command and over-speed flags
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            speed_cmd        <= 16'h0000;
            overspeed        <= 1'b0;
            second_overspeed <= 1'b0;
        end else begin
            speed_cmd        <= active ? cmd_d : 16'h0000;
            overspeed        <= active && (actual_speed > overspeed_level);
            second_overspeed <= active && (actual_speed > second_overspeed_level);
        end
    end
endmodule : shm_speed_clamp
`default_nettype wire
